// ### verilog/codec_mixer_format_defs.vh
// Constants for the codec mixer and data-format control register bank
`ifndef CODEC_MIXER_FORMAT_DEFS_VH
`define CODEC_MIXER_FORMAT_DEFS_VH

// Indirect register indices
`define IDX_LEFT_ADC 4'h0
`define IDX_RIGHT_ADC 4'h1
`define IDX_LEFT_AUX1 4'h2
`define IDX_RIGHT_AUX1 4'h3
`define IDX_LEFT_AUX2 4'h4
`define IDX_RIGHT_AUX2 4'h5
`define IDX_LEFT_DAC 4'h6
`define IDX_RIGHT_DAC 4'h7
`define IDX_RATE_FMT 4'h8
`define REG_COUNT 9

// Reset values, unknown bits taken as zero
`define RST_ADC 8'h00
`define RST_AUX1 8'hE8
`define RST_AUX2 8'hC8
`define RST_DAC 8'h80
`define RST_RATE_FMT 8'h00
// Packed reset image, index 0 in the low byte
`define RST_IMAGE {`RST_RATE_FMT, `RST_DAC, `RST_DAC, `RST_AUX2, `RST_AUX2, \
	`RST_AUX1, `RST_AUX1, `RST_ADC, `RST_ADC}

// ADC input control fields
`define ADC_SRC_HI 7
`define ADC_SRC_LO 6
`define ADC_MIC_BOOST 5
`define ADC_GAIN_HI 3
`define ADC_GAIN_LO 0

// Auxiliary volume fields
`define AUX_OUT_MUTE 7
`define AUX_IN_MUTE 6
`define AUX_BYPASS_MUTE 5
`define AUX_GAIN_HI 4
`define AUX_GAIN_LO 0
`define AUX_GAIN_ZERO_DB 5'h08

// DAC volume fields
`define DAC_MUTE 7
`define DAC_MASTER_HI 6
`define DAC_ATTEN_HI 5
`define DAC_GAIN_LO 0

// Rate and playback format fields
`define FMT_HIGH 7
`define FMT_LOW 6
`define FMT_COMPAND 5
`define FMT_STEREO 4
`define FMT_DIV_HI 3
`define FMT_DIV_LO 1
`define FMT_CLK_BASE 0

// Source select codes
`define SRC_LINE 2'h0
`define SRC_AUX1 2'h1
`define SRC_MIC 2'h2
`define SRC_LOOP 2'h3

// Codec mode field codes
`define MODE_ONE 2'h0
`define MODE_TWO 2'h2
`define MODE_THREE 2'h3

// Sample clock divisors per divide code
`define DIV_0 12'hC00
`define DIV_1 12'h600
`define DIV_2 12'h380
`define DIV_3 12'h300
`define DIV_4 12'h1C0
`define DIV_5 12'h180
`define DIV_6 12'h200
`define DIV_7 12'hA00

`endif

// ### verilog/mixer_channel_decode.v
// One channel of mixer path decoding from its four control registers
`timescale 1ns/10ps
`default_nettype none
`include "codec_mixer_format_defs.vh"

module mixer_channel_decode (
	input wire clock,
	input wire rst_n,
	input wire [7:0] adc_ctl,
	input wire [7:0] aux_one_ctl,
	input wire [7:0] aux_two_ctl,
	input wire [7:0] dac_ctl,
	input wire mode_three,
	input wire atten_mode,
	input wire mode_change_enable,
	output reg [3:0] source_onehot_q,
	output reg loopback_q,
	output reg mic_boost_q,
	output reg [5:0] adc_gain_hdb_q,
	output reg [6:0] aux_one_gain_hdb_q,
	output reg aux_one_bypass_mute_q,
	output reg aux_one_in_mute_q,
	output reg aux_one_out_mute_q,
	output reg [6:0] aux_two_gain_hdb_q,
	output reg aux_two_in_mute_q,
	output reg aux_two_out_mute_q,
	output reg [6:0] master_gain_q,
	output reg [5:0] bus_atten_q,
	output reg bus_mute_q,
	output reg dac_mute_q
);
	wire [1:0] src = adc_ctl[`ADC_SRC_HI:`ADC_SRC_LO]; // Input source code
	wire [3:0] adc_code = adc_ctl[`ADC_GAIN_HI:`ADC_GAIN_LO]; // ADC gain code
	wire [4:0] aux1_code = aux_one_ctl[`AUX_GAIN_HI:`AUX_GAIN_LO];
	wire [4:0] aux2_code = aux_two_ctl[`AUX_GAIN_HI:`AUX_GAIN_LO];
	// Half-dB units: 3 per 1.5 dB step; aux is signed around code 8
	wire [5:0] adc_hdb = {2'h0, adc_code} + {1'b0, adc_code, 1'b0};
	wire [6:0] aux1_off = {2'h0, aux1_code} - {2'h0, `AUX_GAIN_ZERO_DB};
	wire [6:0] aux2_off = {2'h0, aux2_code} - {2'h0, `AUX_GAIN_ZERO_DB};
	wire [6:0] aux1_hdb = aux1_off + {aux1_off[5:0], 1'b0};
	wire [6:0] aux2_hdb = aux2_off + {aux2_off[5:0], 1'b0};

	// Register every decoded control so the analog side sees clean levels
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			source_onehot_q <= 4'h0;
			loopback_q <= 1'b0;
			mic_boost_q <= 1'b0;
			adc_gain_hdb_q <= 6'h00;
			aux_one_gain_hdb_q <= 7'h00;
			aux_one_bypass_mute_q <= 1'b1;
			aux_one_in_mute_q <= 1'b1;
			aux_one_out_mute_q <= 1'b1;
			aux_two_gain_hdb_q <= 7'h00;
			aux_two_in_mute_q <= 1'b1;
			aux_two_out_mute_q <= 1'b1;
			master_gain_q <= 7'h00;
			bus_atten_q <= 6'h00;
			bus_mute_q <= 1'b0;
			dac_mute_q <= 1'b1;
		end else begin
			// Multiplexer only outside mode 3; mode 3 mixes instead
			source_onehot_q <= mode_three ? 4'h0 : (4'h1 << src);
			loopback_q <= (src == `SRC_LOOP);
			mic_boost_q <= !mode_three && adc_ctl[`ADC_MIC_BOOST];
			adc_gain_hdb_q <= adc_hdb;
			aux_one_gain_hdb_q <= aux1_hdb;
			aux_two_gain_hdb_q <= aux2_hdb;
			// Bypass path follows the source select unless in mode 3
			aux_one_bypass_mute_q <= mode_three ? aux_one_ctl[`AUX_BYPASS_MUTE]
				: (src != `SRC_AUX1);
			aux_one_in_mute_q <= !mode_three || aux_one_ctl[`AUX_IN_MUTE];
			aux_two_in_mute_q <= !mode_three || aux_two_ctl[`AUX_IN_MUTE];
			aux_one_out_mute_q <= aux_one_ctl[`AUX_OUT_MUTE];
			aux_two_out_mute_q <= aux_two_ctl[`AUX_OUT_MUTE];
			// Volume byte reads as master gain or bus attenuation
			master_gain_q <= atten_mode ? 7'h00 : dac_ctl[`DAC_MASTER_HI:`DAC_GAIN_LO];
			bus_atten_q <= atten_mode ? dac_ctl[`DAC_ATTEN_HI:`DAC_GAIN_LO] : 6'h00;
			bus_mute_q <= atten_mode && dac_ctl[`DAC_MUTE];
			// Mode change always silences the converter path
			dac_mute_q <= mode_change_enable
				|| (!atten_mode && dac_ctl[`DAC_MUTE]);
		end
	end
endmodule // mixer_channel_decode

`default_nettype wire

// ### verilog/sample_rate_decode.v
// Sample clock base and divisor decode from the rate bits
`timescale 1ns/10ps
`default_nettype none
`include "codec_mixer_format_defs.vh"

module sample_rate_decode (
	input wire clock,
	input wire rst_n,
	input wire [2:0] rate_divide_select,
	input wire clock_base_select,
	input wire alt_rate_enable,
	input wire interface_rate_enable,
	output reg [11:0] divisor_q,
	output reg clock_base_q,
	output reg rate_unavailable_q,
	output reg rate_overridden_q
);
	reg [11:0] div_d; // Divisor for the current code

	// Divisor lookup
	always @* begin
		case (rate_divide_select)
			3'h0: div_d = `DIV_0;
			3'h1: div_d = `DIV_1;
			3'h2: div_d = `DIV_2;
			3'h3: div_d = `DIV_3;
			3'h4: div_d = `DIV_4;
			3'h5: div_d = `DIV_5;
			3'h6: div_d = `DIV_6;
			default: div_d = `DIV_7;
		endcase
	end

	// Registered rate selection; an override hands rate control elsewhere
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			divisor_q <= `DIV_0;
			clock_base_q <= 1'b0;
			rate_unavailable_q <= 1'b0;
			rate_overridden_q <= 1'b0;
		end else begin
			divisor_q <= div_d;
			clock_base_q <= clock_base_select;
			// Codes 4 and 5 need the second base clock
			rate_unavailable_q <= !clock_base_select
				&& (rate_divide_select == 3'h4 || rate_divide_select == 3'h5);
			rate_overridden_q <= alt_rate_enable || interface_rate_enable;
		end
	end
endmodule // sample_rate_decode

`default_nettype wire

// ### verilog/codec_mixer_format_regs.v
// Indirect mixer, volume and format register bank with decoded controls
`timescale 1ns/10ps
`default_nettype none
`include "codec_mixer_format_defs.vh"

module codec_mixer_format_regs (
	input wire clock,
	input wire rst_n,
	// Indexed data access, index already latched by the index register
	input wire [3:0] reg_index,
	input wire reg_write,
	input wire reg_read,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata_q,
	output reg reg_rvalid_q,
	output reg write_refused_q,
	// Mode and configuration flags held elsewhere in the codec
	input wire mode_change_enable,
	input wire playback_mode_change_enable,
	input wire alt_rate_enable,
	input wire interface_rate_enable,
	input wire interface_mode_flag,
	input wire wavetable_enable,
	input wire [1:0] codec_mode_field,
	// Mode decode
	output reg mode_one_q,
	output reg mode_two_q,
	output reg mode_three_q,
	output reg mode_reserved_q,
	// Per-channel mixer controls, bit 0 left and bit 1 right
	output wire [7:0] source_onehot,
	output wire [1:0] loopback,
	output wire [1:0] mic_boost,
	output wire [11:0] adc_gain_hdb,
	output wire [13:0] aux_one_gain_hdb,
	output wire [1:0] aux_one_bypass_mute,
	output wire [1:0] aux_one_in_mute,
	output wire [1:0] aux_one_out_mute,
	output wire [13:0] aux_two_gain_hdb,
	output wire [1:0] aux_two_in_mute,
	output wire [1:0] aux_two_out_mute,
	output wire [13:0] master_gain,
	output wire [11:0] bus_audio_atten,
	output wire [1:0] bus_audio_mute,
	output wire [1:0] dac_mute,
	output reg atten_mode_q,
	// Sample rate
	output wire [11:0] rate_divisor,
	output wire rate_clock_base,
	output wire rate_unavailable,
	output wire rate_overridden,
	// Data format
	output reg format_high_bit_q,
	output reg format_low_bit_q,
	output reg format_compand_q,
	output reg format_reserved_q,
	output reg stereo_q,
	output reg play_mono_duplicate_q,
	output reg capture_mono_left_q,
	output reg capture_follows_play_q
);
	reg [7:0] bank_q [0:`REG_COUNT-1]; // Stored register bytes
	localparam [8*`REG_COUNT-1:0] reset_image = `RST_IMAGE; // Defaults per index
	wire index_valid = (reg_index < `REG_COUNT); // Unmapped index guard
	wire is_rate_fmt = (reg_index == `IDX_RATE_FMT); // Protected register
	wire upper_open = mode_change_enable || playback_mode_change_enable;
	wire lower_open = mode_change_enable;
	wire [7:0] rate_fmt_q = bank_q[`IDX_RATE_FMT]; // Format register alias
	wire mode_three_now = (codec_mode_field == `MODE_THREE); // Live decode
	wire atten_now = interface_mode_flag || wavetable_enable; // Live decode
	// Live mode 1 test, also true for the reserved code
	wire mode_one_now = !codec_mode_field[1];
	wire [7:0] rate_fmt_merged; // Format byte after protection
	wire fmt_refused; // Some protected bit was left unchanged
	genvar gi;

	// Protection on the format register: format and stereo bits need
	// either enable, rate bits need the full mode change enable. The
	// host is expected to open the window first; a closed window simply
	// keeps the old bits so a stray write cannot glitch the converters.
	assign rate_fmt_merged = {
		upper_open ? reg_wdata[7:4] : rate_fmt_q[7:4],
		lower_open ? reg_wdata[3:0] : rate_fmt_q[3:0]
	};
	assign fmt_refused = (!upper_open && (reg_wdata[7:4] != rate_fmt_q[7:4]))
		|| (!lower_open && (reg_wdata[3:0] != rate_fmt_q[3:0]));

	// One storage byte per index, each with its own default
	generate
		for (gi = 0; gi < `REG_COUNT; gi = gi + 1) begin : g_bank
			always @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					bank_q[gi] <= reset_image[gi*8 +: 8];
				end else if (reg_write && reg_index == gi) begin
					// Full byte kept, reserved bits too, for stable readback
					if (gi == `IDX_RATE_FMT) begin
						bank_q[gi] <= rate_fmt_merged;
					end else begin
						bank_q[gi] <= reg_wdata;
					end
				end
			end
		end
	endgenerate

	// Read path and refusal flag; an unmapped index reads zero
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_q <= 8'h00;
			reg_rvalid_q <= 1'b0;
			write_refused_q <= 1'b0;
		end else begin
			reg_rvalid_q <= reg_read;
			if (reg_read) begin
				reg_rdata_q <= index_valid ? bank_q[reg_index] : 8'h00;
			end
			// Pulse when a write tries to change a closed part of the format byte
			write_refused_q <= reg_write && is_rate_fmt && fmt_refused;
		end
	end

	// Mode decode; the reserved code behaves like mode 1 for mixing
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode_one_q <= 1'b1;
			mode_two_q <= 1'b0;
			mode_three_q <= 1'b0;
			mode_reserved_q <= 1'b0;
			atten_mode_q <= 1'b0;
		end else begin
			mode_one_q <= (codec_mode_field == `MODE_ONE);
			mode_two_q <= (codec_mode_field == `MODE_TWO);
			mode_three_q <= mode_three_now;
			mode_reserved_q <= (codec_mode_field == 2'h1);
			atten_mode_q <= atten_now;
		end
	end

	// Left and right paths share one decoder body
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_chan
			mixer_channel_decode u_chan (
				.clock(clock),
				.rst_n(rst_n),
				.adc_ctl(bank_q[`IDX_LEFT_ADC + gi]),
				.aux_one_ctl(bank_q[`IDX_LEFT_AUX1 + gi]),
				.aux_two_ctl(bank_q[`IDX_LEFT_AUX2 + gi]),
				.dac_ctl(bank_q[`IDX_LEFT_DAC + gi]),
				.mode_three(mode_three_now),
				.atten_mode(atten_now),
				.mode_change_enable(mode_change_enable),
				.source_onehot_q(source_onehot[gi*4 +: 4]),
				.loopback_q(loopback[gi]),
				.mic_boost_q(mic_boost[gi]),
				.adc_gain_hdb_q(adc_gain_hdb[gi*6 +: 6]),
				.aux_one_gain_hdb_q(aux_one_gain_hdb[gi*7 +: 7]),
				.aux_one_bypass_mute_q(aux_one_bypass_mute[gi]),
				.aux_one_in_mute_q(aux_one_in_mute[gi]),
				.aux_one_out_mute_q(aux_one_out_mute[gi]),
				.aux_two_gain_hdb_q(aux_two_gain_hdb[gi*7 +: 7]),
				.aux_two_in_mute_q(aux_two_in_mute[gi]),
				.aux_two_out_mute_q(aux_two_out_mute[gi]),
				.master_gain_q(master_gain[gi*7 +: 7]),
				.bus_atten_q(bus_audio_atten[gi*6 +: 6]),
				.bus_mute_q(bus_audio_mute[gi]),
				.dac_mute_q(dac_mute[gi])
			);
		end
	endgenerate

	// Rate decode from the low nibble of the format register
	sample_rate_decode u_rate (
		.clock(clock),
		.rst_n(rst_n),
		.rate_divide_select(rate_fmt_q[`FMT_DIV_HI:`FMT_DIV_LO]),
		.clock_base_select(rate_fmt_q[`FMT_CLK_BASE]),
		.alt_rate_enable(alt_rate_enable),
		.interface_rate_enable(interface_rate_enable),
		.divisor_q(rate_divisor),
		.clock_base_q(rate_clock_base),
		.rate_unavailable_q(rate_unavailable),
		.rate_overridden_q(rate_overridden)
	);

	// Data format decode. In mode 1 and the reserved code the high format bit is forced low and
	// the same settings serve capture; modes 2 and 3 capture elsewhere.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			format_high_bit_q <= 1'b0;
			format_low_bit_q <= 1'b0;
			format_compand_q <= 1'b0;
			format_reserved_q <= 1'b0;
			stereo_q <= 1'b0;
			play_mono_duplicate_q <= 1'b1;
			capture_mono_left_q <= 1'b1;
			capture_follows_play_q <= 1'b1;
		end else begin
			format_high_bit_q <= !mode_one_now && rate_fmt_q[`FMT_HIGH];
			format_low_bit_q <= rate_fmt_q[`FMT_LOW];
			format_compand_q <= rate_fmt_q[`FMT_COMPAND];
			// Codes 100 and 111 have no format behind them
			format_reserved_q <= !mode_one_now && rate_fmt_q[`FMT_HIGH]
				&& (rate_fmt_q[`FMT_LOW] == rate_fmt_q[`FMT_COMPAND]);
			stereo_q <= rate_fmt_q[`FMT_STEREO];
			play_mono_duplicate_q <= !rate_fmt_q[`FMT_STEREO];
			// Mono capture takes the left channel only while this byte rules it
			capture_mono_left_q <= mode_one_now && !rate_fmt_q[`FMT_STEREO];
			capture_follows_play_q <= mode_one_now;
		end
	end
endmodule // codec_mixer_format_regs

`default_nettype wire

// ### sim/mixer_regs_chk.sv
// Port checks for the mixer and format register bank
`timescale 1ns/10ps
`default_nettype none
`include "codec_mixer_format_defs.vh"
module mixer_regs_chk (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [3:0] reg_index,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rvalid_q,
	input wire logic write_refused_q,
	input wire logic mode_change_enable,
	input wire logic [1:0] codec_mode_field,
	input wire logic [7:0] source_onehot,
	input wire logic [1:0] mic_boost,
	input wire logic [1:0] aux_one_in_mute,
	input wire logic [1:0] aux_two_in_mute,
	input wire logic [1:0] aux_one_out_mute,
	input wire logic [13:0] master_gain,
	input wire logic [11:0] bus_audio_atten,
	input wire logic atten_mode_q,
	input wire logic [1:0] dac_mute,
	input wire logic [11:0] rate_divisor,
	input wire logic rate_clock_base,
	input wire logic rate_unavailable
);
	// One clock domain, codec reset disables every check
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Mode held two edges, so the decode stage has caught up
	sequence s_mode3; (codec_mode_field == `MODE_THREE) [*2]; endsequence
	sequence s_other; (codec_mode_field != `MODE_THREE) [*2]; endsequence
	// Host write into the left first auxiliary register
	sequence s_wr_aux; reg_write && reg_index == `IDX_LEFT_AUX1; endsequence
	AST_READ_ANSWER: assert property (reg_rvalid_q == $past(reg_read))
		else $error("read answer not one cycle after strobe");
	AST_REFUSED: assert property (write_refused_q |-> $past(reg_write && !mode_change_enable))
		else $error("refusal without a closed write");
	AST_OUT_MUTE: assert property (s_wr_aux |-> ##2 aux_one_out_mute[0] == $past(reg_wdata[7], 2))
		else $error("aux output mute does not follow bit 7");
	AST_MCE_MUTE: assert property (mode_change_enable |=> dac_mute == 2'b11)
		else $error("dac not muted under mode change");
	AST_BOOST_OFF: assert property (s_mode3 |=> mic_boost == 2'b00)
		else $error("mic boost active in mode 3");
	AST_NO_MUX: assert property (s_mode3 |=> source_onehot == 8'h00)
		else $error("input multiplexer active in mode 3");
	AST_IN_MUTE: assert property (s_other |=> (aux_one_in_mute & aux_two_in_mute) == 2'b11)
		else $error("aux input mutes not forced");
	AST_SPLIT: assert property (atten_mode_q ? master_gain == 14'h0000 : bus_audio_atten == 12'h000)
		else $error("dac volume reading mixes both forms");
	AST_RATE_NA: assert property (rate_unavailable |-> !rate_clock_base && (rate_divisor == 12'h1C0 || rate_divisor == 12'h180))
		else $error("unavailable flag on a usable rate");
endmodule // mixer_regs_chk
bind codec_mixer_format_regs mixer_regs_chk i_chk (.*);
`default_nettype wire

// ### sim/host_model.sv
// Host side model doing index and data cycles on the bank
`timescale 1ns/10ps
`default_nettype none
module host_model (
	input wire logic clock,
	output var logic [3:0] reg_index,
	output var logic reg_write,
	output var logic reg_read,
	output var logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata_q,
	input wire logic reg_rvalid_q
);
	// Idle bus at time zero
	initial begin
		reg_index = 4'hF;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_wdata = 8'hFF;
	end
	// Index and data go out together, then both are scrambled on release
	task automatic wr(input logic [3:0] i, input logic [7:0] d);
		@(posedge clock);
		reg_index <= i;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		reg_wdata <= ~d;
		reg_index <= ~i;
	endtask
	// Read answer is taken only with its valid flag, else unknown
	task automatic rd(input logic [3:0] i, output logic [7:0] d);
		@(posedge clock);
		reg_index <= i;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		reg_index <= ~i;
		#1;
		d = (reg_rvalid_q === 1'b1) ? reg_rdata_q : 8'hXX;
	endtask
endmodule // host_model
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the mixer and format register bank
`timescale 1ns/10ps
`default_nettype none
`include "codec_mixer_format_defs.vh"
module tb;
	logic clock, rst_n, mode_change_enable, playback_mode_change_enable, alt_rate_enable;
	logic interface_rate_enable, interface_mode_flag, wavetable_enable;
	logic [1:0] codec_mode_field;
	wire [3:0] reg_index;
	wire reg_write, reg_read;
	wire [7:0] reg_wdata;
	logic [7:0] reg_rdata_q, source_onehot;
	logic reg_rvalid_q, write_refused_q, atten_mode_q, rate_clock_base, rate_unavailable;
	logic rate_overridden, mode_one_q, mode_two_q, mode_three_q, mode_reserved_q, stereo_q;
	logic play_mono_duplicate_q, capture_mono_left_q, capture_follows_play_q;
	logic format_high_bit_q, format_low_bit_q, format_compand_q, format_reserved_q;
	logic [1:0] loopback, mic_boost, aux_one_bypass_mute, aux_one_in_mute, aux_one_out_mute;
	logic [1:0] aux_two_in_mute, aux_two_out_mute, bus_audio_mute, dac_mute;
	logic [11:0] adc_gain_hdb, bus_audio_atten, rate_divisor;
	logic [13:0] aux_one_gain_hdb, aux_two_gain_hdb, master_gain;
	int n_errors = 0, check_count = 0, cycles = 0;
	codec_mixer_format_regs i_dut (.*);
	host_model i_host (.*);
	// 20 MHz clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Decoded outputs lag a register by one edge; two spare edges
	task automatic settle();
		repeat (3) @(posedge clock);
		#1;
	endtask
	task automatic rdchk(input logic [3:0] i, input logic [7:0] exp);
		logic [7:0] d;
		i_host.rd(i, d);
		chk(d, exp);
	endtask
	task automatic t_reset();
		logic [7:0] dflt [9] = '{8'h00, 8'h00, 8'hE8, 8'hE8, 8'hC8, 8'hC8, 8'h80, 8'h80, 8'h00};
		settle();
		chk(dac_mute, 2'b11);
		for (int i = 0; i < 9; i++) rdchk(i[3:0], dflt[i]);
	endtask
	task automatic t_mode();
		logic [1:0] code [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			codec_mode_field <= code[i];
			settle();
			chk({mode_one_q, mode_two_q, mode_three_q, mode_reserved_q}, 4'h8 >> i);
		end
	endtask
	// Every bit, reserved ones too, kept; writes and reads back to back
	task automatic t_store();
		logic [7:0] d;
		@(posedge clock);
		codec_mode_field <= 2'h0;
		for (int p = 0; p < 2; p++) for (int i = 0; i < 8; i++) begin
			d = {i[3:0], ~i[3:0]} ^ {8{p[0]}};
			i_host.wr(i[3:0], d);
			rdchk(i[3:0], d);
		end
		i_host.wr(4'hC, 8'hFF);
		rdchk(4'hC, 8'h00);
	endtask
	task automatic t_adc();
		for (int s = 0; s < 4; s++) begin
			i_host.wr(`IDX_LEFT_ADC, {s[1:0], 2'b10, 4'hF - s[3:0]});
			settle();
			chk(source_onehot[3:0], 4'h1 << s);
			chk(mic_boost[0], 1'b1);
			chk(adc_gain_hdb[5:0], 16'((15 - s) * 3));
			chk(aux_one_bypass_mute[0], s != 1);
		end
		@(posedge clock);
		codec_mode_field <= 2'h3;
		i_host.wr(`IDX_LEFT_ADC, 8'hE0);
		settle();
		chk({loopback[0], source_onehot[3:0], mic_boost[0]}, 6'h20);
		i_host.wr(`IDX_LEFT_ADC, 8'h60);
		settle();
		chk(loopback[0], 1'b0);
	endtask
	task automatic t_aux();
		i_host.wr(`IDX_LEFT_AUX1, 8'h70);
		i_host.wr(`IDX_RIGHT_AUX2, 8'h80);
		settle();
		chk(aux_one_gain_hdb[6:0], 7'h18);
		chk({aux_one_in_mute[0], aux_one_bypass_mute[0], aux_one_out_mute[0]}, 3'h6);
		chk(aux_two_gain_hdb[13:7], 7'h68);
		chk({aux_two_in_mute[1], aux_two_out_mute[1]}, 2'b01);
		@(posedge clock);
		codec_mode_field <= 2'h0;
		settle();
		chk({aux_two_in_mute[1], aux_one_in_mute[0], aux_one_bypass_mute[0]}, 3'h6);
	endtask
	task automatic t_dac();
		i_host.wr(`IDX_LEFT_DAC, 8'h85);
		settle();
		chk({dac_mute[0], master_gain[6:0], bus_audio_atten[5:0]}, 14'h2140);
		i_host.wr(`IDX_LEFT_DAC, 8'h7F);
		settle();
		chk({dac_mute[0], master_gain[6:0]}, 8'h7F);
		for (int f = 1; f < 3; f++) begin
			@(posedge clock);
			{interface_mode_flag, wavetable_enable} <= f[1:0];
			i_host.wr(`IDX_RIGHT_DAC, 8'hBF);
			settle();
			chk({bus_audio_mute[1], bus_audio_atten[11:6], master_gain[13:7]}, 14'h3F80);
			chk(dac_mute[1], 1'b0);
		end
		@(posedge clock);
		{interface_mode_flag, wavetable_enable} <= 2'b00;
		mode_change_enable <= 1'b1;
		settle();
		chk(dac_mute, 2'b11);
	endtask
	task automatic t_rate();
		logic [11:0] dv [8] = '{12'hC00, 12'h600, 12'h380, 12'h300, 12'h1C0, 12'h180, 12'h200, 12'hA00};
		for (int c = 0; c < 16; c++) begin
			i_host.wr(`IDX_RATE_FMT, {4'h0, c[2:0], c[3]});
			#1;
			chk(write_refused_q, 1'b0);
			settle();
			chk(rate_divisor, dv[c[2:0]]);
			chk(rate_clock_base, c[3]);
			chk(rate_unavailable, !c[3] && (c[2:0] == 4 || c[2:0] == 5));
		end
		@(posedge clock);
		alt_rate_enable <= 1'b1;
		settle();
		chk(rate_overridden, 1'b1);
		@(posedge clock);
		alt_rate_enable <= 1'b0;
		interface_rate_enable <= 1'b1;
		settle();
		chk(rate_overridden, 1'b1);
		@(posedge clock);
		interface_rate_enable <= 1'b0;
		mode_change_enable <= 1'b0;
		playback_mode_change_enable <= 1'b1;
		i_host.wr(`IDX_RATE_FMT, 8'h10);
		#1;
		chk(write_refused_q, 1'b1);
		rdchk(`IDX_RATE_FMT, 8'h1F);
		settle();
		chk({stereo_q, play_mono_duplicate_q, capture_mono_left_q, capture_follows_play_q}, 4'h9);
		chk(rate_overridden, 1'b0);
		@(posedge clock);
		playback_mode_change_enable <= 1'b0;
		codec_mode_field <= 2'h2;
		i_host.wr(`IDX_RATE_FMT, 8'h00);
		#1;
		chk(write_refused_q, 1'b1);
		rdchk(`IDX_RATE_FMT, 8'h1F);
		chk(capture_follows_play_q, 1'b0);
		// Format bits: high bit counts in modes 2 and 3 only
		@(posedge clock);
		playback_mode_change_enable <= 1'b1;
		i_host.wr(`IDX_RATE_FMT, 8'hB0);
		settle();
		chk({format_high_bit_q, format_low_bit_q, format_compand_q, format_reserved_q}, 4'hA);
		@(posedge clock);
		codec_mode_field <= 2'h0;
		settle();
		chk({format_high_bit_q, format_low_bit_q, format_compand_q, format_reserved_q}, 4'h2);
	endtask
	// Reset held eight cycles, then the scenarios in turn
	initial begin
		rst_n = 1'b0;
		mode_change_enable = 1'b0;
		playback_mode_change_enable = 1'b0;
		alt_rate_enable = 1'b0;
		interface_rate_enable = 1'b0;
		interface_mode_flag = 1'b0;
		wavetable_enable = 1'b0;
		codec_mode_field = 2'h0;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		t_reset();
		t_mode();
		t_store();
		t_adc();
		t_aux();
		t_dac();
		t_rate();
		finish_test();
	end
endmodule // tb
`default_nettype wire
